// ===== verilog/hbp_host_port.sv
// Purpose: Host bus pin front end: qualifier, strobes, address latch, straps, sleep.
// Assumes: All host pins are asynchronous to pclk and pass two flops first.
// Notes: Local select is registered, so it trails the pins by three pclk cycles.
`timescale 1ns/100ps
// Summary of operation
// - Address decode valid only while the active-low qualifier is low.
// - Asynchronous write strobe is active low; a falling edge counts a write only while the qualifier is low.
// - Address and qualifier are latched on the address strobe rising edge.
// - Without serial ROM, data-in pin low gives 8-bit, high 16-bit; ignored for 32-bit.
// - Power-down input low puts the chip to sleep; high means normal.
// - Serial ROM used only when its enable strap is high.
// - Local select asserted low when qualifier low and A15-A4 match base.
// - Mode strap low gives synchronous bus, high gives asynchronous or burst.
module hbp_host_port #(
  parameter bit WIDE32 = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire hbp_pkg::hbp_host_pins_t host_pins,
  input wire logic serial_rom_data_in,
  input wire logic serial_rom_enable_strap,
  input wire logic local_bus_mode_strap,
  input wire logic full_chip_sleep_n,
  output logic local_select_n,
  output logic chip_asleep,
  output logic bus_async_mode,
  output logic [1:0] bus_width
);
  import hbp_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int PW = 23;
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_s;
  // Active-low pins are inverted about the flops so their reset reads inactive
  localparam logic [PW-1:0] PIN_INV = {15'h0000, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  assign pin_raw = {host_pins.addr, host_pins.address_qualifier_n,
                    host_pins.address_latch_strobe_n, host_pins.async_write_strobe_n,
                    host_pins.sync_write_read_select, serial_rom_data_in,
                    serial_rom_enable_strap, local_bus_mode_strap, full_chip_sleep_n};

  hbp_sync2 #(.WIDTH(PW)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .rst_val(PIN_INV),
    .d(pin_raw),
    .q(pin_s)
  );

  logic [15:1] a_s;
  logic qual_n_s;
  logic ads_n_s;
  logic wr_n_s;
  logic swr_s;
  logic rom_di_s;
  logic rom_en_s;
  logic mode_s;
  logic sleep_n_s;
  assign {a_s, qual_n_s, ads_n_s, wr_n_s, swr_s, rom_di_s, rom_en_s, mode_s, sleep_n_s}
    = pin_s ^ PIN_INV;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic ctrl_sleep_en_reg, ctrl_sleep_en_next;
  logic [7:0] base_reg, base_next;
  logic [15:0] latch_addr_reg, latch_addr_next;
  logic ads_n_d_reg, wr_n_d_reg;
  logic [15:0] wr_cnt_reg, wr_cnt_next;
  logic [2:0] settle_reg, settle_next;
  logic strap_done_reg, strap_done_next;
  hbp_straps_t straps_reg, straps_next;
  logic sel_n_reg, sel_n_next;
  logic sleep_reg, sleep_next;
  logic last_wr_reg, last_wr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;

  logic ads_rise;
  logic wr_fall;
  assign ads_rise = !ads_n_d_reg && ads_n_s;
  assign wr_fall = wr_n_d_reg && !wr_n_s;

  // ----------------------------------------------------------------
  // Host pin logic: latch, decode, straps, sleep
  // ----------------------------------------------------------------
  always_comb
  begin
    latch_addr_next = latch_addr_reg;
    wr_cnt_next = wr_cnt_reg;
    settle_next = settle_reg;
    strap_done_next = strap_done_reg;
    straps_next = straps_reg;
    last_wr_next = last_wr_reg;
    // Capture A15-A1 with the qualifier at the strobe rising edge
    if (ads_rise)
      latch_addr_next = {a_s, qual_n_s};
    // Async write strobe counts only when the qualifier is valid
    if (wr_fall && !qual_n_s)
      wr_cnt_next = wr_cnt_reg + 16'h0001;
    // Direction of a synchronous access while qualified
    if (!qual_n_s)
      last_wr_next = swr_s;
    // Straps caught once after reset, after the synchronisers settle
    if (!strap_done_reg)
    begin
      if (settle_reg == 3'(HBP_STRAP_CYC))
      begin
        strap_done_next = 1'b1;
        straps_next.rom_enabled = rom_en_s;
        straps_next.async_mode = mode_s;
        if (WIDE32)
          straps_next.width = HBP_W32;
        else if (rom_en_s)
          straps_next.width = HBP_W16;
        else
          straps_next.width = rom_di_s ? HBP_W16 : HBP_W8;
      end
      else
        settle_next = settle_reg + 3'h1;
    end
    // Decode of A15-A4 against the programmed base high byte
    sel_n_next = !(!qual_n_s && (a_s[15:8] == base_reg) && (a_s[7:4] == 4'h0));
    sleep_next = ctrl_sleep_en_reg && !sleep_n_s;
  end

  // ----------------------------------------------------------------
  // APB slave; one wait-free access phase
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_sleep_en_next = ctrl_sleep_en_reg;
    base_next = base_reg;
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    if (psel && !penable)
    begin
      pready_next = 1'b1;
      prdata_next = 32'h00000000;
      case (paddr)
        HBP_CTRL_OFF: prdata_next[HBP_CTRL_SLEEP_EN_BIT] = ctrl_sleep_en_reg;
        HBP_BASE_OFF: prdata_next[7:0] = base_reg;
        HBP_STAT_OFF:
        begin
          prdata_next[HBP_STAT_ROM_EN_BIT] = straps_reg.rom_enabled;
          prdata_next[HBP_STAT_WIDTH16_BIT] = straps_reg.width == HBP_W16;
          prdata_next[HBP_STAT_ASYNC_BIT] = straps_reg.async_mode;
          prdata_next[HBP_STAT_SLEEP_BIT] = sleep_reg;
          prdata_next[HBP_STAT_SEL_BIT] = !sel_n_reg;
          prdata_next[HBP_STAT_WR_BIT] = last_wr_reg;
          prdata_next[HBP_STAT_QUAL_BIT] = !qual_n_s;
        end
        HBP_ADDR_OFF: prdata_next[15:0] = latch_addr_reg;
        HBP_CNT_OFF: prdata_next[15:0] = wr_cnt_reg;
        default: pslverr_next = 1'b1;
      endcase
    end
    // Writes take effect at the completing edge only
    if (psel && penable && pready_reg && pwrite)
    begin
      case (paddr)
        HBP_CTRL_OFF: ctrl_sleep_en_next = pwdata[HBP_CTRL_SLEEP_EN_BIT];
        HBP_BASE_OFF: base_next = pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Registers; straps and status hold defined values until captured
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_sleep_en_reg <= HBP_CTRL_RST;
      base_reg <= HBP_BASE_RST;
      latch_addr_reg <= HBP_ADDR_RST;
      ads_n_d_reg <= 1'b1;
      wr_n_d_reg <= 1'b1;
      wr_cnt_reg <= HBP_CNT_RST;
      settle_reg <= 3'h0;
      strap_done_reg <= 1'b0;
      straps_reg <= '{rom_enabled: 1'b0, async_mode: 1'b0, width: HBP_W8};
      sel_n_reg <= 1'b1;
      sleep_reg <= 1'b0;
      last_wr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      ctrl_sleep_en_reg <= ctrl_sleep_en_next;
      base_reg <= base_next;
      latch_addr_reg <= latch_addr_next;
      ads_n_d_reg <= ads_n_s;
      wr_n_d_reg <= wr_n_s;
      wr_cnt_reg <= wr_cnt_next;
      settle_reg <= settle_next;
      strap_done_reg <= strap_done_next;
      straps_reg <= straps_next;
      sel_n_reg <= sel_n_next;
      sleep_reg <= sleep_next;
      last_wr_reg <= last_wr_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign local_select_n = sel_n_reg;
  assign chip_asleep = sleep_reg;
  assign bus_async_mode = straps_reg.async_mode;
  assign bus_width = straps_reg.width;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_strobe_rise;
    !ads_n_d_reg ##0 ads_n_s;
  endsequence

  chk_addr_latch: assert property (s_strobe_rise |=> latch_addr_reg == $past({a_s, qual_n_s}))
    else $error("address not latched on strobe rise");
  chk_sel_needs_qual: assert property (!sel_n_reg |-> $past(!qual_n_s))
    else $error("local select without qualifier");
  chk_sel_decode: assert property (!qual_n_s && a_s[15:8] == base_reg && a_s[7:4] == 4'h0
    |=> !sel_n_reg)
    else $error("local select missing on match");
  chk_wr_count: assert property (wr_fall && !qual_n_s |=> wr_cnt_reg == $past(wr_cnt_reg) + 16'h0001)
    else $error("write strobe not counted");
  chk_sleep_entry: assert property (ctrl_sleep_en_reg && !sleep_n_s |=> chip_asleep)
    else $error("sleep not entered");
  chk_sleep_exit: assert property (sleep_n_s |=> !chip_asleep)
    else $error("sleep while input high");
  chk_width_strap: assert property ($rose(strap_done_reg) && !WIDE32 && !straps_reg.rom_enabled
    |-> bus_width == ($past(rom_di_s) ? HBP_W16 : HBP_W8))
    else $error("bus width strap wrong");
  chk_mode_strap: assert property ($rose(strap_done_reg) |-> bus_async_mode == $past(mode_s)
    && straps_reg.rom_enabled == $past(rom_en_s))
    else $error("mode or rom strap wrong");
  chk_dir_track: assert property (!qual_n_s |=> last_wr_reg == $past(swr_s))
    else $error("direction not tracked");
  chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb ready timing");
endmodule

// ===== verilog/hbp_pkg.sv
// Purpose: Shared constants, types and register map of the host bus pin front end.
// Assumes: APB register access, 32-bit data, 25 MHz pclk.
// Notes: Offsets are byte addresses; each register is one aligned word.
package hbp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] HBP_CTRL_OFF = 8'h00;
  localparam logic [7:0] HBP_BASE_OFF = 8'h04;
  localparam logic [7:0] HBP_STAT_OFF = 8'h08;
  localparam logic [7:0] HBP_ADDR_OFF = 8'h0C;
  localparam logic [7:0] HBP_CNT_OFF = 8'h10;

  // Field positions
  localparam int HBP_CTRL_SLEEP_EN_BIT = 0;
  localparam int HBP_STAT_ROM_EN_BIT = 0;
  localparam int HBP_STAT_WIDTH16_BIT = 1;
  localparam int HBP_STAT_ASYNC_BIT = 2;
  localparam int HBP_STAT_SLEEP_BIT = 3;
  localparam int HBP_STAT_SEL_BIT = 4;
  localparam int HBP_STAT_WR_BIT = 5;
  localparam int HBP_STAT_QUAL_BIT = 6;

  // Reset values
  localparam logic HBP_CTRL_RST = 1'b1;
  localparam logic [7:0] HBP_BASE_RST = 8'h03;
  localparam logic [15:0] HBP_ADDR_RST = 16'h0000;
  localparam logic [15:0] HBP_CNT_RST = 16'h0000;

  // Strap capture waits this long after reset so pins settle through the synchroniser
  localparam int HBP_STRAP_SETTLE_NS = 200;
  localparam int HBP_CLK_NS = 40;
  localparam int HBP_STRAP_CYC = (HBP_STRAP_SETTLE_NS + HBP_CLK_NS - 1) / HBP_CLK_NS;

  // Bus width selected by straps, or 32-bit by the WIDE32 parameter
  typedef enum logic [1:0] {HBP_W8, HBP_W16, HBP_W32} hbp_width_t;

  // Host pin group
  typedef struct packed {
    logic [15:1] addr;
    logic address_qualifier_n;
    logic address_latch_strobe_n;
    logic async_write_strobe_n;
    logic sync_write_read_select;
  } hbp_host_pins_t;

  // Captured straps
  typedef struct packed {
    logic rom_enabled;
    logic async_mode;
    hbp_width_t width;
  } hbp_straps_t;

endpackage

// ===== verilog/hbp_sync2.sv
// Purpose: Two-flop synchroniser for a bundle of level inputs.
// Assumes: Inputs are asynchronous to pclk.
// Notes: Only the second stage may be read by logic.
`timescale 1ns/100ps
module hbp_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] rst_val,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  // Two stages, both reset to zero; data is XORed with rst_val, a constant tie at the instance
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d ^ rst_val;
      q <= meta_reg;
    end
  end
endmodule

// ===== sim/hbp_host_model.sv
// Purpose: Host CPU model that drives the host bus pins of the front end.
// Assumes: Pins change by non-blocking assignment right after a pclk rising edge.
// Notes: Each strobe level is held three cycles, above the two-cycle minimum.
`timescale 1ns/100ps
module hbp_host_model
(
  input wire logic pclk,
  output hbp_pkg::hbp_host_pins_t pins
);
  import hbp_pkg::*;
  // ----------------------------------------
  // Pin tasks
  // ----------------------------------------
  // Idle: qualifier high, write strobe high, latch strobe low
  initial pins = 19'h7FFFA;

  // Address, qualifier and sync direction change together
  task automatic put_addr(input logic [15:0] a, input logic q, input logic dir);
    @(posedge pclk);
    pins.addr <= a[15:1];
    pins.address_qualifier_n <= q;
    pins.sync_write_read_select <= dir;
  endtask

  // Write strobe pulses low; latch strobe pulses high so its rising edge latches
  task automatic pulse(input bit wr);
    @(posedge pclk);
    if (wr) pins.async_write_strobe_n <= 1'b0;
    else pins.address_latch_strobe_n <= 1'b1;
    repeat (3) @(posedge pclk);
    pins.async_write_strobe_n <= 1'b1;
    pins.address_latch_strobe_n <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
endmodule

// ===== sim/host_bus_pin_interface_tb.sv
// Purpose: Self-checking bench for the host bus pin front end.
// Assumes: APB answers within a bounded count; pin results settle within five cycles.
// Notes: Straps are only captured after reset, so each strap case costs a reset.
`timescale 1ns/100ps
module host_bus_pin_interface_tb;
  import hbp_pkg::*;
  logic pclk = 1'b0;
  logic presetn;
  logic psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er, local_select_n, chip_asleep, bus_async_mode;
  logic [1:0] bus_width;
  logic rom_di, rom_en, mode, sleep_n;
  hbp_host_pins_t host_pins;
  int err_count = 0, checks = 0;
  logic [7:0] offs [4] = '{HBP_CTRL_OFF, HBP_BASE_OFF, HBP_ADDR_OFF, HBP_CNT_OFF};
  logic [31:0] rstv [4] = '{32'(HBP_CTRL_RST), 32'(HBP_BASE_RST), 32'(HBP_ADDR_RST),
    32'(HBP_CNT_RST)};
  logic [15:0] la [5] = '{16'h0300, 16'h0300, 16'h0310, 16'h0200, 16'h120E};
  logic lq [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic le [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  always #20 pclk = ~pclk;

  hbp_host_port u_hbp_host_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_pins(host_pins), .serial_rom_data_in(rom_di),
    .serial_rom_enable_strap(rom_en), .local_bus_mode_strap(mode),
    .full_chip_sleep_n(sleep_n), .local_select_n(local_select_n), .chip_asleep(chip_asleep),
    .bus_async_mode(bus_async_mode), .bus_width(bus_width));
  hbp_host_model u_hbp_host_model (.pclk(pclk), .pins(host_pins));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Only a missing answer is a timeout, even when it comes on the last try
    if (pready !== 1'b1)
    begin
      err_count++;
      close_out();
    end
  endtask

  task automatic restart(input logic e, input logic di, input logic m);
    rom_en <= e;
    rom_di <= di;
    mode <= m;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    // Bus idle before the first reset; straps are set by restart
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    sleep_n <= 1'b1;
    // Strap cases: none/8-bit sync, none/16-bit async, ROM fitted
    for (int i = 0; i < 3; i++)
    begin
      restart(i == 2, i == 1, i == 1);
      check("bus_width", 32'(bus_width), (i == 0) ? 32'h0 : 32'h1);
      check("bus_async_mode", 32'(bus_async_mode), 32'(i == 1));
      apb(1'b0, HBP_STAT_OFF, 32'h0);
      check("stat rom", 32'(rd[HBP_STAT_ROM_EN_BIT]), 32'(i == 2));
      check("stat width16", 32'(rd[HBP_STAT_WIDTH16_BIT]), 32'(i != 0));
      check("stat async", 32'(rd[HBP_STAT_ASYNC_BIT]), 32'(i == 1));
      check("pslverr mapped", 32'(er), 32'h0);
    end
    $display("test straps done");
    foreach (offs[k])
    begin
      apb(1'b0, offs[k], 32'h0);
      check("reset value", rd, rstv[k]);
    end
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    check("pslverr", 32'(er), 32'h1);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped read", rd, 32'h0);
    $display("test registers done");
    // Decode; the last case follows a new base byte
    foreach (la[k])
    begin
      if (k == 4) apb(1'b1, HBP_BASE_OFF, 32'h12);
      u_hbp_host_model.put_addr(la[k], lq[k], 1'b0);
      repeat (5) @(posedge pclk);
      check("local_select_n", 32'(local_select_n), 32'(le[k]));
    end
    // Qualified match still stands; status shows select, qualifier and read direction
    apb(1'b0, HBP_STAT_OFF, 32'h0);
    check("stat selected", 32'(rd[HBP_STAT_SEL_BIT]), 32'h1);
    check("stat qualifier", 32'(rd[HBP_STAT_QUAL_BIT]), 32'h1);
    check("stat read dir", 32'(rd[HBP_STAT_WR_BIT]), 32'h0);
    u_hbp_host_model.put_addr(16'h120E, 1'b0, 1'b1);
    repeat (5) @(posedge pclk);
    apb(1'b0, HBP_STAT_OFF, 32'h0);
    check("stat write dir", 32'(rd[HBP_STAT_WR_BIT]), 32'h1);
    apb(1'b0, HBP_BASE_OFF, 32'h0);
    check("base readback", rd, 32'h12);
    $display("test decode done");
    u_hbp_host_model.put_addr(16'hABCC, 1'b1, 1'b1);
    u_hbp_host_model.pulse(1'b0);
    apb(1'b0, HBP_ADDR_OFF, 32'h0);
    check("latched address", rd, 32'h0000_ABCD);
    u_hbp_host_model.put_addr(16'h5678, 1'b0, 1'b0);
    u_hbp_host_model.pulse(1'b0);
    apb(1'b0, HBP_ADDR_OFF, 32'h0);
    check("latched address", rd, 32'h0000_5678);
    $display("test latch done");
    // Two qualified writes, one unqualified; count is read only
    u_hbp_host_model.pulse(1'b1);
    u_hbp_host_model.pulse(1'b1);
    u_hbp_host_model.put_addr(16'h5678, 1'b1, 1'b0);
    u_hbp_host_model.pulse(1'b1);
    apb(1'b1, HBP_CNT_OFF, 32'h0000_FFFF);
    apb(1'b0, HBP_CNT_OFF, 32'h0);
    check("write count", rd, 32'h2);
    $display("test write strobe done");
    @(posedge pclk);
    sleep_n <= 1'b0;
    repeat (5) @(posedge pclk);
    check("chip_asleep", 32'(chip_asleep), 32'h1);
    apb(1'b0, HBP_STAT_OFF, 32'h0);
    check("stat asleep", 32'(rd[HBP_STAT_SLEEP_BIT]), 32'h1);
    sleep_n <= 1'b1;
    repeat (5) @(posedge pclk);
    check("chip_asleep", 32'(chip_asleep), 32'h0);
    // With the sleep enable cleared the pin alone must not put the chip to sleep
    apb(1'b1, HBP_CTRL_OFF, 32'h0);
    apb(1'b0, HBP_CTRL_OFF, 32'h0);
    check("ctrl readback", rd, 32'h0);
    sleep_n <= 1'b0;
    repeat (5) @(posedge pclk);
    check("chip_asleep gated", 32'(chip_asleep), 32'h0);
    sleep_n <= 1'b1;
    $display("test sleep done");
    close_out();
  end
endmodule
